//--- logic/timer8_pkg.sv
package timer8_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_CMPA = 8'h08;
   localparam logic [7:0] ADDR_CMPB = 8'h0C;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   // Control register fields
   localparam int CTRL_WAVE_LSB = 0;
   localparam int CTRL_SETB_LSB = 4;
   localparam int CTRL_SETA_LSB = 6;
   localparam int CTRL_W = 8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Flag bit positions
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_CMPB = 2;
   localparam int NUM_FLAGS = 3;
   // Channels, channel A drives TOP in some modes
   localparam int NUM_CHANNELS = 2;
   localparam int CH_A = 0;
   // Counter extremes and reset values
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   // Waveform generation modes
   typedef enum logic [2:0] {
      WAVE_NORMAL = 3'b000,
      WAVE_PHASE_MAX = 3'b001,
      WAVE_CLEAR_ON_MATCH = 3'b010,
      WAVE_FAST_MAX = 3'b011,
      WAVE_RSVD4 = 3'b100,
      WAVE_PHASE_CMPA = 3'b101,
      WAVE_RSVD6 = 3'b110,
      WAVE_FAST_CMPA = 3'b111
   } wave_mode_t;
   // Compare output settings
   typedef enum logic [1:0] {
      OUT_NONE = 2'b00,
      OUT_TOGGLE = 2'b01,
      OUT_CLEAR = 2'b10,
      OUT_SET = 2'b11
   } out_setting_t;
   // Count direction for the dual-slope mode
   typedef enum logic {
      DIR_UP = 1'b0,
      DIR_DOWN = 1'b1
   } dir_t;
endpackage

//--- logic/timer_state_if.sv
`timescale 1ns/1ps
`default_nettype none
// Shared counter state, broadcast to each compare channel
interface timer_state_if;
   logic [7:0] count;      // Current count
   logic [7:0] topValue;   // Present TOP
   logic tick;             // Timer clock enable
   logic block;            // Match blocked after count write
   logic run;              // Mode is a defined one
   logic isNonPwm;         // Normal, clear-on-match or reserved
   logic isFast;           // Single slope
   logic isPhase;          // Dual slope
   logic wgmTop;           // Top mode-select bit
   logic atTop;            // Count equals TOP
   logic atBottom;         // Count equals zero
   logic dirDown;          // Dual slope counting down
   modport timer (output count, topValue, tick, block, run, isNonPwm, isFast, isPhase,
      wgmTop, atTop, atBottom, dirDown);
   modport channel (input count, topValue, tick, block, run, isNonPwm, isFast, isPhase,
      wgmTop, atTop, atBottom, dirDown);
endinterface // timer_state_if
`default_nettype wire

//--- logic/sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
   parameter int N = 3
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [N-1:0] setEv,
   input wire logic [N-1:0] clearEv,
   output logic [N-1:0] flags
);
   logic [N-1:0] flags_reg; // Held flag state
   // Set wins so an event in the clearing cycle survives
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_reg <= '0;
      else
         flags_reg <= (flags_reg & ~clearEv) | setEv;
   end
   assign flags = flags_reg;
endmodule // sticky_flags
`default_nettype wire

//--- logic/compare_channel.sv
`timescale 1ns/1ps
`default_nettype none
module compare_channel #(
   parameter bit IS_CHANNEL_A = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   timer_state_if.channel tim,
   input wire timer8_pkg::out_setting_t setting,
   input wire logic [7:0] bufValue,
   output logic [7:0] activeValue,
   output logic matchEvent,
   output logic waveOut
);
   import timer8_pkg::*;
   logic [7:0] active_reg; // Compare value in use under PWM
   logic waveOut_reg;      // Output level, zero from reset
   logic match;            // Unblocked equality
   logic upLvl;            // Level an up-count match gives
   assign activeValue = tim.isNonPwm ? bufValue : active_reg;
   assign match = tim.run && !tim.block && (tim.count == activeValue);
   assign matchEvent = tim.tick && match;
   assign upLvl = (setting == OUT_SET);
   assign waveOut = waveOut_reg;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         active_reg <= CMP_RESET;
      else if (tim.isNonPwm || (tim.tick && tim.atTop))
         active_reg <= bufValue;
   end
   // Output action on each timer tick in a defined (non-reserved) mode
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         waveOut_reg <= 1'b0;
      else if (tim.tick && tim.run)
      begin
         case (setting)
            OUT_NONE: waveOut_reg <= waveOut_reg;
            // toggle; in PWM only channel A, and only with TOP from compare A
            OUT_TOGGLE:
               if (match && (tim.isNonPwm || (IS_CHANNEL_A && tim.wgmTop)))
                  waveOut_reg <= ~waveOut_reg;
            default:
               if (tim.isNonPwm)
               begin
                  if (match)
                     waveOut_reg <= upLvl;
               end
               else if (tim.isFast)
               begin
                  if (tim.atTop)
                     waveOut_reg <= ~upLvl;
                  else if (match)
                     waveOut_reg <= upLvl;
               end
               else
               begin
                  if (tim.atTop && (activeValue == tim.topValue))
                     waveOut_reg <= ~upLvl;
                  else if (tim.atBottom)
                     waveOut_reg <= match ? upLvl : ~upLvl;
                  else if (match)
                     waveOut_reg <= tim.dirDown ? ~upLvl : upLvl;
               end
         endcase
      end
   end
endmodule // compare_channel
`default_nettype wire

//--- logic/timer8_waveform_modes.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_modes #(
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tickEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic waveOutA,
   output logic waveOutB,
   output logic [timer8_pkg::NUM_FLAGS-1:0] flagsOut
);
   import timer8_pkg::*;

   // Bus decode
   logic setupPhase;       // First cycle of a transfer
   logic accessDone;       // Access edge, write lands here
   logic wrEn;             // Write taking effect
   logic [7:0] addrLow;    // Byte address seen by the decode
   logic addrHit;          // Address belongs to the map

   // Software state
   logic [CTRL_W-1:0] ctrl_reg;              // Mode and settings
   logic [7:0] cmpBuf_reg [NUM_CHANNELS];    // Values written by software
   logic [31:0] prdata_reg;                  // Read data captured in setup

   // Counter state
   logic [7:0] count_reg;  // Count value
   logic [7:0] count_next; // Next count on a tick
   dir_t dir_reg;          // Dual slope direction
   dir_t dir_next;         // Next direction on a tick
   logic block_reg;        // Blocks matches one tick after a write
   logic countWrite;       // Software writing the count

   // Mode decode
   wave_mode_t mode;       // Current waveform mode
   logic [7:0] topValue;   // TOP for current mode
   logic ovfEvent;         // Overflow condition this tick

   // Per channel
   out_setting_t chSetting [NUM_CHANNELS]; // Output setting per channel
   logic [7:0] chActive [NUM_CHANNELS];    // Compare value in use
   logic [NUM_CHANNELS-1:0] chMatch;       // Match pulses
   logic [NUM_CHANNELS-1:0] chWave;        // Output levels

   // Flags
   logic [NUM_FLAGS-1:0] flagSet;   // Hardware set events
   logic [NUM_FLAGS-1:0] flagClear; // Software clear strobes
   logic [NUM_FLAGS-1:0] flags;     // Current flag levels

   timer_state_if tim();

   // Bus phases; zero wait states so the access phase always ends
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable;
   assign addrLow = paddr[7:0];
   assign addrHit = (addrLow == ADDR_CTRL) || (addrLow == ADDR_COUNT) ||
      (addrLow == ADDR_CMPA) || (addrLow == ADDR_CMPB) || (addrLow == ADDR_FLAGS);
   assign wrEn = accessDone && pwrite && addrHit;
   assign pready = accessDone;
   // Unmapped addresses answer with an error, nothing stored
   assign pslverr = accessDone && !addrHit;
   assign prdata = prdata_reg;

   // Read data sampled in the setup cycle, held through the access
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata_reg <= READ_ZERO;
      else if (setupPhase && !pwrite)
      begin
         case (addrLow)
            ADDR_CTRL: prdata_reg <= {24'h00_0000, ctrl_reg};
            // Live count, shows the block's own state
            ADDR_COUNT: prdata_reg <= {24'h00_0000, count_reg};
            ADDR_CMPA: prdata_reg <= {24'h00_0000, cmpBuf_reg[CH_A]};
            ADDR_CMPB: prdata_reg <= {24'h00_0000, cmpBuf_reg[CH_A + 1]};
            ADDR_FLAGS: prdata_reg <= {29'h0000_0000, flags};
            default: prdata_reg <= READ_ZERO;
         endcase
      end
   end

   // Control register, steers mode and output settings
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_reg <= CTRL_RESET;
      else if (wrEn && (addrLow == ADDR_CTRL))
         ctrl_reg <= pwdata[CTRL_W-1:0];
   end

   // Compare values; the channel decides whether they are buffered
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmpBuf_reg[CH_A] <= CMP_RESET;
         cmpBuf_reg[CH_A + 1] <= CMP_RESET;
      end
      else if (wrEn)
      begin
         // compare A write visible at once outside PWM
         if (addrLow == ADDR_CMPA)
            cmpBuf_reg[CH_A] <= pwdata[7:0];
         if (addrLow == ADDR_CMPB)
            cmpBuf_reg[CH_A + 1] <= pwdata[7:0];
      end
   end

   // Mode fields
   assign mode = wave_mode_t'(ctrl_reg[CTRL_WAVE_LSB +: 3]);
   assign chSetting[CH_A] = out_setting_t'(ctrl_reg[CTRL_SETA_LSB +: 2]);
   assign chSetting[CH_A + 1] = out_setting_t'(ctrl_reg[CTRL_SETB_LSB +: 2]);
   assign countWrite = wrEn && (addrLow == ADDR_COUNT);

   // Mode class decode shared with the channels
   always_comb
   begin
      tim.isNonPwm = 1'b0;
      tim.isFast = 1'b0;
      tim.isPhase = 1'b0;
      tim.run = 1'b1;
      case (mode)
         WAVE_NORMAL: tim.isNonPwm = 1'b1;
         WAVE_CLEAR_ON_MATCH: tim.isNonPwm = 1'b1;
         WAVE_FAST_MAX: tim.isFast = 1'b1;
         WAVE_FAST_CMPA: tim.isFast = 1'b1;
         WAVE_PHASE_MAX: tim.isPhase = 1'b1;
         WAVE_PHASE_CMPA: tim.isPhase = 1'b1;
         default:
         begin
            tim.isNonPwm = 1'b1;
            tim.run = 1'b0;
         end
      endcase
   end

   // TOP is the maximum or channel A's compare value
   assign topValue = ctrl_reg[CTRL_WAVE_LSB + 2] ? chActive[CH_A] : COUNT_MAX;

   // Broadcast counter state
   assign tim.count = count_reg;
   assign tim.topValue = topValue;
   // only the enable advances the timer
   assign tim.tick = tickEn;
   assign tim.block = block_reg;
   assign tim.wgmTop = ctrl_reg[CTRL_WAVE_LSB + 2];
   assign tim.atTop = (count_reg == topValue);
   assign tim.atBottom = (count_reg == COUNT_BOTTOM);
   assign tim.dirDown = (dir_reg == DIR_DOWN);

   // Next count and direction for one tick
   always_comb
   begin
      count_next = count_reg;
      dir_next = DIR_UP;
      case (mode)
         WAVE_NORMAL: count_next = count_reg + COUNT_ONE;
         // clear at compare A; a missed match wraps past maximum
         WAVE_CLEAR_ON_MATCH:
            if (chMatch[CH_A])
               count_next = COUNT_BOTTOM;
            else
               count_next = count_reg + COUNT_ONE;
         // bottom follows TOP on the next tick
         WAVE_FAST_MAX, WAVE_FAST_CMPA:
            if (tim.atTop)
               count_next = COUNT_BOTTOM;
            else
               count_next = count_reg + COUNT_ONE;
         // turn at TOP after one tick there
         WAVE_PHASE_MAX, WAVE_PHASE_CMPA:
         begin
            case (dir_reg)
               DIR_UP:
                  if (tim.atTop)
                  begin
                     dir_next = DIR_DOWN;
                     count_next = count_reg - COUNT_ONE;
                  end
                  else
                  begin
                     dir_next = DIR_UP;
                     count_next = count_reg + COUNT_ONE;
                  end
               default:
                  if (tim.atBottom)
                  begin
                     dir_next = DIR_UP;
                     count_next = count_reg + COUNT_ONE;
                  end
                  else
                  begin
                     dir_next = DIR_DOWN;
                     count_next = count_reg - COUNT_ONE;
                  end
            endcase
         end
         // Reserved: hold
         default: count_next = count_reg;
      endcase
   end

   // Count register; a software write beats any tick
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= COUNT_BOTTOM;
      else if (countWrite)
         count_reg <= pwdata[7:0];
      else if (tickEn)
         count_reg <= count_next;
   end

   // Direction; outside dual slope it rests at up
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         dir_reg <= DIR_UP;
      else if (!tim.isPhase)
         dir_reg <= DIR_UP;
      else if (tickEn && !countWrite)
         dir_reg <= dir_next;
   end

   // One tick of match blocking after a count write, even when stopped
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         block_reg <= 1'b0;
      else if (countWrite)
         block_reg <= 1'b1;
      else if (tickEn)
         block_reg <= 1'b0;
   end

   // Overflow condition per mode
   always_comb
   begin
      ovfEvent = 1'b0;
      case (mode)
         // set as the count wraps from maximum to zero
         WAVE_NORMAL, WAVE_CLEAR_ON_MATCH: ovfEvent = (count_reg == COUNT_MAX);
         WAVE_FAST_MAX, WAVE_FAST_CMPA: ovfEvent = tim.atTop;
         WAVE_PHASE_MAX, WAVE_PHASE_CMPA: ovfEvent = tim.atBottom;
         default: ovfEvent = 1'b0;
      endcase
   end

   // flags rise at the tick that ends the match or overflow cycle
   assign flagSet[FLAG_OVF] = tickEn && !countWrite && ovfEvent;
   assign flagSet[FLAG_CMPA] = chMatch[CH_A] && !countWrite;
   assign flagSet[FLAG_CMPB] = chMatch[CH_A + 1] && !countWrite;
   // Write one to clear
   assign flagClear = (wrEn && (addrLow == ADDR_FLAGS)) ? pwdata[NUM_FLAGS-1:0] : '0;

   sticky_flags #(
      .N(NUM_FLAGS)
   ) u_flags (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .setEv(flagSet),
      .clearEv(flagClear),
      .flags(flags)
   );

   // One compare unit per channel
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++)
      begin : g_ch
         compare_channel #(
            .IS_CHANNEL_A(ch == CH_A)
         ) u_cmp (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .tim(tim),
            .setting(chSetting[ch]),
            .bufValue(cmpBuf_reg[ch]),
            .activeValue(chActive[ch]),
            .matchEvent(chMatch[ch]),
            .waveOut(chWave[ch])
         );
      end
   endgenerate

   // Outputs straight from channel and flag flip-flops
   assign waveOutA = chWave[CH_A];
   assign waveOutB = chWave[CH_A + 1];
   assign flagsOut = flags;
endmodule // timer8_waveform_modes
`default_nettype wire

//--- test/timer8_waveform_modes_props.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_modes_props
   import timer8_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tickEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic waveOutA,
   input wire logic waveOutB,
   input wire logic [timer8_pkg::NUM_FLAGS-1:0] flagsOut
);
   logic [7:0] shadowCtrl_reg; // Control copy, lands with the write
   logic flagWr;               // Flag clear access
   logic mapped;               // Address decodes to a register
   logic [2:0] mode;           // Shadowed mode
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   assign flagWr = psel && penable && pwrite && paddr == ADDR_W'(ADDR_FLAGS);
   assign mapped = paddr inside {ADDR_W'(ADDR_CTRL), ADDR_W'(ADDR_COUNT), ADDR_W'(ADDR_CMPA),
      ADDR_W'(ADDR_CMPB), ADDR_W'(ADDR_FLAGS)};
   assign mode = shadowCtrl_reg[2:0];
   // Track control so mode-dependent checks need no internal probes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shadowCtrl_reg <= CTRL_RESET;
      end
      else if (psel && penable && pwrite && paddr == ADDR_W'(ADDR_CTRL))
      begin
         shadowCtrl_reg <= pwdata[7:0];
      end
   end
   // Access phase of a bus transfer
   sequence apbAcc;
      psel && penable;
   endsequence
   // A cycle with no timer tick
   sequence noTick;
      !tickEn;
   endsequence
   chk_access_answer: assert property (apbAcc |-> pready && (pslverr == !mapped))
      else $error("access phase answer wrong");
   chk_idle_quiet: assert property (!psel |-> !pready && !pslverr)
      else $error("ready or error while idle");
   chk_unmapped_zero: assert property (apbAcc ##0 (!pwrite && pslverr) |-> prdata == READ_ZERO)
      else $error("unmapped read not zero");
   chk_waves_hold: assert property (noTick |=> $stable(waveOutA) && $stable(waveOutB))
      else $error("wave output moved without tick");
   chk_flags_hold: assert property (noTick ##0 !flagWr |=> $stable(flagsOut))
      else $error("flags moved without tick");
   chk_flags_sticky: assert property (!flagWr |=> ($past(flagsOut) & ~flagsOut) == '0)
      else $error("flag cleared without write");
   chk_flag_clear: assert property (flagWr && !tickEn
      |=> ({29'h0, flagsOut} & $past(pwdata)) == 32'h0)
      else $error("flag not cleared by write");
   chk_none_a_hold: assert property ((shadowCtrl_reg[7:6] == OUT_NONE
      || (shadowCtrl_reg[7:6] == OUT_TOGGLE && mode[0] && !mode[2])) |=> $stable(waveOutA))
      else $error("output A moved with no action");
   chk_none_b_hold: assert property ((shadowCtrl_reg[5:4] == OUT_NONE
      || (shadowCtrl_reg[5:4] == OUT_TOGGLE && mode[0])) |=> $stable(waveOutB))
      else $error("output B moved with no action");
   chk_reserved_idle: assert property ((mode inside {WAVE_RSVD4, WAVE_RSVD6}) && !flagWr
      |=> $stable(flagsOut) && $stable(waveOutA) && $stable(waveOutB))
      else $error("activity in reserved mode");
endmodule // timer8_waveform_modes_props
bind timer8_waveform_modes timer8_waveform_modes_props #(.ADDR_W(ADDR_W)) props_u (
   .ref_clk(ref_clk), .rst_n(rst_n), .tickEn(tickEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .waveOutA(waveOutA), .waveOutB(waveOutB), .flagsOut(flagsOut));
`default_nettype wire

//--- test/timer8_waveform_modes_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_modes_bench;
   import timer8_pkg::*;
   logic ref_clk, rst_n, tickEn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic waveOutA, waveOutB, rdErr;
   logic [NUM_FLAGS-1:0] flagsOut;
   int num_errors, comparisons;
   logic [7:0] regAddr [5] = '{ADDR_CTRL, ADDR_COUNT, ADDR_CMPA, ADDR_CMPB, ADDR_FLAGS};
   timer8_waveform_modes #(.ADDR_W(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .tickEn(tickEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .waveOutA(waveOutA), .waveOutB(waveOutB), .flagsOut(flagsOut));
   // 200 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task print_verdict;
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] e, input logic [31:0] got);
      comparisons++;
      if (got !== e)
      begin
         num_errors++;
         $display("FAIL %s expected %0h seen %0h", what, e, got);
      end
   endtask
   // One bus transfer; a dead slave is caught by the watchdog alone
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Wait for the answer, however many cycles it takes
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      // Answer taken at the ready edge only
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 32'h1, 32'(pready));
      // Let the access edge settle so later checks see what it launched
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("read %0h", a), e, rdData);
   endtask
   // Exactly n timer ticks, then let the tick edge settle
   task ticks(input int n);
      @(posedge ref_clk);
      tickEn <= 1'b1;
      repeat (n) @(posedge ref_clk);
      tickEn <= 1'b0;
      #1;
   endtask
   task cwa(input logic e);
      chk("waveOutA", 32'(e), 32'(waveOutA));
   endtask
   task cf(input logic [2:0] e);
      chk("flagsOut", 32'(e), 32'(flagsOut));
   endtask
   // Watchdog, well beyond the roughly 3000 cycles of the run
   initial
   begin
      #200000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      tickEn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      num_errors = 0;
      comparisons = 0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      // Reset contents and an unmapped place
      foreach (regAddr[i]) rc(regAddr[i], READ_ZERO);
      rc(8'h14, READ_ZERO);
      chk("pslverr", 32'h1, 32'(rdErr));
      // Normal mode wrap and overflow
      wr(ADDR_COUNT, 32'hFD);
      ticks(2);
      rc(ADDR_COUNT, 32'hFF);
      cf(3'h0);
      ticks(1);
      rc(ADDR_COUNT, 32'h00);
      cf(3'h1);
      ticks(1);
      cf(3'h7);
      wr(ADDR_FLAGS, 32'h7);
      cf(3'h0);
      // Clear on match with toggling output A
      wr(ADDR_CTRL, 32'h42);
      wr(ADDR_CMPA, 32'h03);
      wr(ADDR_COUNT, 32'h00);
      wr(ADDR_FLAGS, 32'h7);
      ticks(4);
      rc(ADDR_COUNT, 32'h00);
      cwa(1'b1);
      cf(3'h2);
      ticks(3);
      // New TOP below the count is missed until the wrap
      wr(ADDR_CMPA, 32'h01);
      wr(ADDR_FLAGS, 32'h7);
      ticks(253);
      rc(ADDR_COUNT, 32'h00);
      cf(3'h1);
      cwa(1'b1);
      ticks(2);
      rc(ADDR_COUNT, 32'h00);
      cwa(1'b0);
      // Fast PWM, A non-inverting, B inverting, fixed TOP
      wr(ADDR_CTRL, 32'hB3);
      wr(ADDR_CMPA, 32'h40);
      wr(ADDR_CMPB, 32'h40);
      wr(ADDR_COUNT, 32'hFE);
      wr(ADDR_FLAGS, 32'h7);
      ticks(2);
      rc(ADDR_COUNT, 32'h00);
      cwa(1'b1);
      chk("waveOutB", 32'h0, 32'(waveOutB));
      cf(3'h1);
      ticks(32);
      // Mid-period write stays in the buffer
      wr(ADDR_CMPA, 32'h30);
      ticks(17);
      cwa(1'b1);
      ticks(16);
      cwa(1'b0);
      chk("waveOutB", 32'h1, 32'(waveOutB));
      // Bottom compare gives a one-tick spike
      wr(ADDR_CMPA, 32'h00);
      ticks(191);
      cwa(1'b1);
      ticks(1);
      cwa(1'b0);
      // Maximum compare gives a constant level
      wr(ADDR_CMPA, 32'hFF);
      ticks(255);
      ticks(255);
      cwa(1'b1);
      // Dual slope, fixed TOP, B toggle has no effect
      wr(ADDR_CTRL, 32'h91);
      wr(ADDR_CMPA, 32'h02);
      wr(ADDR_COUNT, 32'hFE);
      ticks(2);
      rc(ADDR_COUNT, 32'hFE);
      wr(ADDR_FLAGS, 32'h7);
      ticks(252);
      ticks(3);
      chk("ovf", 32'h1, 32'(flagsOut[FLAG_OVF]));
      cwa(1'b1);
      ticks(2);
      cwa(1'b0);
      rc(ADDR_COUNT, 32'h03);
      ticks(505);
      cwa(1'b0);
      ticks(1);
      cwa(1'b1);
      // Bottom compare keeps the non-inverted output low
      wr(ADDR_CMPA, 32'h00);
      ticks(512);
      cwa(1'b0);
      ticks(510);
      cwa(1'b0);
      // Reserved mode holds the counter
      wr(ADDR_CTRL, 32'h04);
      ticks(5);
      rc(ADDR_COUNT, 32'h01);
      print_verdict();
   end
endmodule // timer8_waveform_modes_bench
`default_nettype wire
